// [tb/phy_status_id_advert_regs_tb.sv]
// Self-checking bench for the status, identifier and advertisement bank.
// Assumes zero-wait APB slave with read data captured in the setup phase.
`timescale 1ns/1ps
`default_nettype none

module phy_status_id_advert_regs_tb;
  // Identifier values, arbitrary
  localparam logic [15:0] ID_HI = 16'hA5C3;
  localparam logic [15:0] ID_LO = 16'hB539;

  // Bench signals
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h00000000;
  logic [3:0]  pstrb   = 4'h0;
  logic [3:0]  strb    = 4'h3;
  logic [4:0]  want    = 5'h00;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        an_done, rf_live, link_ok, jab_live, p_ack;
  logic        rf_adv, ps_adv, ffd, fhd, sfd, shd;
  logic [4:0]  sel;
  logic [31:0] rd;
  logic        er;
  int          bad_count  = 0;
  int          n_compared = 0;

  // Clock
  always #25 pclk = ~pclk;

  psia_cond_model cond (.pclk(pclk), .want(want), .autoneg_done(an_done),
    .remote_fault_live(rf_live), .link_valid(link_ok), .jabber_live(jab_live),
    .partner_ack(p_ack));

  psia_regs #(.ORG_IDENT_UPPER(16'hA5C3), .ORG_IDENT_LOWER(6'h2D), .MODEL_NUMBER(6'h13),
    .REVISION_NUMBER(4'h9)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .autoneg_done(an_done),
    .remote_fault_live(rf_live), .link_valid(link_ok), .jabber_live(jab_live),
    .partner_ack(p_ack), .remote_fault_advert(rf_adv), .pause_advert(ps_adv),
    .fast_full_duplex_advert(ffd), .fast_half_duplex_advert(fhd),
    .slow_full_duplex_advert(sfd), .slow_half_duplex_advert(shd), .advert_selector(sel));

  // One APB transfer; held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    pstrb   <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) bad_count++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
  endtask

  // Word compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Error flag compare
  task automatic chk_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read and compare data and error
  task automatic rdc(input logic [7:0] a, input logic [15:0] e, input logic ee);
    apb(1'b0, a, 16'h0000);
    chk(rd, {16'h0000, e});
    chk_flag(er, ee);
  endtask

  // Advertised fields at the output ports
  task automatic chk_adv(input logic [10:0] e);
    chk({21'h000000, rf_adv, ps_adv, ffd, fhd, sfd, shd, sel}, {21'h000000, e});
  endtask

  // Toggle live levels for four cycles, then let them settle
  task automatic pulse(input logic [4:0] m);
    @(posedge pclk);
    want <= want ^ m;
    repeat (4) @(posedge pclk);
    want <= want ^ m;
    repeat (5) @(posedge pclk);
  endtask

  // Reset for two cycles
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // Counts, verdict, end of run
  task automatic test_done();
    $display("Counts: compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    test_done();
  end

  // Test sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values
    rdc(8'h04, 16'h7809, 1'b0);
    rdc(8'h08, ID_HI, 1'b0);
    rdc(8'h0C, ID_LO, 1'b0);
    rdc(8'h10, 16'h01E1, 1'b0);
    chk_adv(11'h1E1);
    $display("Test reset values done");
    // Writes to fixed registers, reserved bits kept zero
    apb(1'b1, 8'h04, 16'hF87F);
    apb(1'b1, 8'h08, 16'hFFFF);
    apb(1'b1, 8'h0C, 16'hFFFF);
    rdc(8'h04, 16'h7809, 1'b0);
    rdc(8'h08, ID_HI, 1'b0);
    rdc(8'h0C, ID_LO, 1'b0);
    $display("Test fixed registers done");
    // Advertisement writable fields, all ones then all zeros
    apb(1'b1, 8'h10, 16'hE7FF);
    rdc(8'h10, 16'h25FF, 1'b0);
    chk_adv(11'h7FF);
    // Upper byte strobe alone, then lower byte strobe alone
    strb = 4'h2;
    apb(1'b1, 8'h10, 16'h0000);
    rdc(8'h10, 16'h00FF, 1'b0);
    chk_adv(11'h0FF);
    strb = 4'h1;
    apb(1'b1, 8'h10, 16'h2500);
    rdc(8'h10, 16'h0000, 1'b0);
    strb = 4'h3;
    apb(1'b1, 8'h10, 16'h0000);
    rdc(8'h10, 16'h0000, 1'b0);
    chk_adv(11'h000);
    $display("Test advertisement done");
    // Unmapped and misaligned addresses refused
    rdc(8'h00, 16'h0000, 1'b1);
    rdc(8'h14, 16'h0000, 1'b1);
    rdc(8'h05, 16'h0000, 1'b1);
    apb(1'b1, 8'h00, 16'h01E1);
    rdc(8'h10, 16'h0000, 1'b0);
    apb(1'b1, 8'h10, 16'h01E1);
    $display("Test unmapped done");
    // Negotiation done, partner ack and link come up
    @(posedge pclk);
    want <= 5'b10101;
    repeat (5) @(posedge pclk);
    rdc(8'h10, 16'h41E1, 1'b0);
    rdc(8'h04, 16'h7829, 1'b0);
    rdc(8'h04, 16'h782D, 1'b0);
    $display("Test live levels done");
    // Link drop latched low, then live again
    pulse(5'b00100);
    rdc(8'h04, 16'h7829, 1'b0);
    rdc(8'h04, 16'h782D, 1'b0);
    $display("Test link latch done");
    // Remote fault and jabber latched high, cleared by read
    pulse(5'b01010);
    rdc(8'h04, 16'h783F, 1'b0);
    rdc(8'h04, 16'h782D, 1'b0);
    $display("Test high latches done");
    // Reset in mid-run clears the fault latch, latches link low and restores writable fields to reset values
    apb(1'b1, 8'h10, 16'h0000);
    pulse(5'b01000);
    do_reset();
    repeat (5) @(posedge pclk);
    rdc(8'h10, 16'h41E1, 1'b0);
    chk_adv(11'h1E1);
    rdc(8'h04, 16'h7829, 1'b0);
    $display("Test mid-run reset done");
    test_done();
  end
endmodule

`default_nettype wire

// [tb/psia_cond_model.sv]
// Line-side condition source standing in for the PHY's live status levels.
// Assumes the bench sets want after a rising edge; levels follow one edge later.
`timescale 1ns/1ps
`default_nettype none

module psia_cond_model (
  // Clock
  input  wire logic       pclk,
  // Wanted levels: autoneg, remote fault, link, jabber, partner ack
  input  wire logic [4:0] want,
  // Live levels into the bank
  output logic            autoneg_done,
  output logic            remote_fault_live,
  output logic            link_valid,
  output logic            jabber_live,
  output logic            partner_ack
);
  // Levels change only just after a rising edge
  always @(posedge pclk) begin
    {autoneg_done, remote_fault_live, link_valid, jabber_live, partner_ack} <= want;
  end
endmodule

`default_nettype wire

// [verilog/psia_latch.sv]
// Latching flag for one condition: latch-high, or latch-low if ACTIVE_LOW.
// Assumes live is synchronous to pclk; clr is a one-cycle read pulse.
`timescale 1ns/1ps
`default_nettype none

module psia_latch #(
  parameter logic ACTIVE_LOW = 1'b0
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Condition and clear
  input  wire logic live,
  input  wire logic clr,
  // Value as read
  output logic      value
);

  typedef struct packed {
    logic flag;
  } psia_latch_state_t;

  psia_latch_state_t st;
  psia_latch_state_t next_st;

  // Event sets the flag; set wins over clear
  always_comb begin
    next_st      = st;
    next_st.flag = (live ^ ACTIVE_LOW) | (st.flag & ~clr);
  end

  // Flag loads ACTIVE_LOW at reset so both kinds read 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{flag: ACTIVE_LOW};
    end else begin
      st <= next_st;
    end
  end

  assign value = st.flag ^ ACTIVE_LOW;

endmodule

`default_nettype wire

// [verilog/psia_params.svh]
// Constants of the PHY status, identifier and advertisement register bank.
// Assumes inclusion by bare name from the package and design files.
`ifndef PSIA_PARAMS_SVH
`define PSIA_PARAMS_SVH

// Register indices; byte address is four times the index
`define PSIA_IDX_STATUS   6'h01
`define PSIA_IDX_ID_HIGH  6'h02
`define PSIA_IDX_ID_LOW   6'h03
`define PSIA_IDX_ADVERT   6'h04

// Status register field positions
`define PSIA_ST_T4        15
`define PSIA_ST_CAP_HI    14
`define PSIA_ST_CAP_LO    11
`define PSIA_ST_PREAMBLE  6
`define PSIA_ST_AN_DONE   5
`define PSIA_ST_RFAULT    4
`define PSIA_ST_AN_ABLE   3
`define PSIA_ST_LINK      2
`define PSIA_ST_JABBER    1
`define PSIA_ST_EXT       0

// Advertisement register field positions
`define PSIA_ADV_NP       15
`define PSIA_ADV_ACK      14
`define PSIA_ADV_RF       13
`define PSIA_ADV_PAUSE    10
`define PSIA_ADV_T4       9
`define PSIA_ADV_ABIL_HI  8
`define PSIA_ADV_ABIL_LO  5
`define PSIA_ADV_SEL_HI   4
`define PSIA_ADV_SEL_LO   0

// Fixed and reset values
`define PSIA_ST_CAPS_VAL  4'hF
`define PSIA_ADV_ABIL_RST 4'hF
`define PSIA_ADV_SEL_RST  5'h01
`define PSIA_ADV_RF_RST   1'h0
`define PSIA_ADV_PS_RST   1'h0

`endif

// [verilog/psia_pkg.sv]
// Types of the PHY status, identifier and advertisement register bank.
// Assumes the constants header is on the include path.
`include "psia_params.svh"

package psia_pkg;

  // Register selected by an address
  typedef enum logic [2:0] {
    psia_reg_none    = 3'b000,
    psia_reg_status  = 3'b001,
    psia_reg_id_high = 3'b010,
    psia_reg_id_low  = 3'b011,
    psia_reg_advert  = 3'b100
  } psia_reg_t;

  // State of the bank top
  typedef struct packed {
    logic [15:0] rdata;
    logic        slverr;
    logic        rd_status;
    logic        adv_rf;
    logic        adv_pause;
    logic [3:0]  adv_ability;
    logic [4:0]  adv_sel;
  } psia_state_t;

endpackage

// [verilog/psia_regs.sv]
// APB register bank: link status and capability, identifiers, advertisement.
// Assumes live PHY conditions arrive asynchronously; APB master on pclk.
`timescale 1ns/1ps
`default_nettype none
`include "psia_params.svh"

module psia_regs #(
  parameter logic [15:0] ORG_IDENT_UPPER = 16'h1234, // Arbitrary value
  parameter logic [5:0]  ORG_IDENT_LOWER = 6'h15,    // Arbitrary value
  parameter logic [5:0]  MODEL_NUMBER    = 6'h2A,    // Arbitrary value
  parameter logic [3:0]  REVISION_NUMBER = 4'h5      // Arbitrary value
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Live PHY conditions
  input  wire logic        autoneg_done,
  input  wire logic        remote_fault_live,
  input  wire logic        link_valid,
  input  wire logic        jabber_live,
  input  wire logic        partner_ack,
  // Advertised abilities to the negotiation engine
  output logic             remote_fault_advert,
  output logic             pause_advert,
  output logic             fast_full_duplex_advert,
  output logic             fast_half_duplex_advert,
  output logic             slow_full_duplex_advert,
  output logic             slow_half_duplex_advert,
  output logic      [4:0]  advert_selector
);

  psia_pkg::psia_state_t st;
  psia_pkg::psia_state_t next_st;

  logic [4:0]  live_sync;
  logic        an_done_s;
  logic        rf_live_s;
  logic        link_live_s;
  logic        jab_live_s;
  logic        ack_s;
  logic        rf_val;
  logic        link_val;
  logic        jab_val;
  logic        setup_ph;
  logic        access_ph;
  logic        rd_done;
  logic        wr_adv;
  logic        rf_clr;
  logic        link_clr;
  logic        jab_clr;
  logic [15:0] status_word;
  logic [15:0] advert_word;
  psia_pkg::psia_reg_t sel_reg;

  // Address to register; only aligned words hit
  function automatic psia_pkg::psia_reg_t decode(input logic [7:0] addr);
    if (addr[1:0] != 2'b00) begin
      decode = psia_pkg::psia_reg_none;
    end else if (addr[7:2] == `PSIA_IDX_STATUS) begin
      decode = psia_pkg::psia_reg_status;
    end else if (addr[7:2] == `PSIA_IDX_ID_HIGH) begin
      decode = psia_pkg::psia_reg_id_high;
    end else if (addr[7:2] == `PSIA_IDX_ID_LOW) begin
      decode = psia_pkg::psia_reg_id_low;
    end else if (addr[7:2] == `PSIA_IDX_ADVERT) begin
      decode = psia_pkg::psia_reg_advert;
    end else begin
      decode = psia_pkg::psia_reg_none;
    end
  endfunction

  // Live conditions cross into pclk
  psia_sync #(
    .W (5)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({partner_ack, jabber_live, link_valid, remote_fault_live, autoneg_done}),
    .dout    (live_sync)
  );

  assign an_done_s   = live_sync[0];
  assign rf_live_s   = live_sync[1];
  assign link_live_s = live_sync[2];
  assign jab_live_s  = live_sync[3];
  assign ack_s       = live_sync[4];

  // Bus phases; zero wait states
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign sel_reg   = decode(paddr);
  assign rd_done   = access_ph & ~pwrite & st.rd_status;
  assign wr_adv    = access_ph & pwrite & (sel_reg == psia_pkg::psia_reg_advert);

  // Clear only what the completing read reported; a new event wins
  assign rf_clr   = rd_done & st.rdata[`PSIA_ST_RFAULT];
  assign jab_clr  = rd_done & st.rdata[`PSIA_ST_JABBER];
  assign link_clr = rd_done & ~st.rdata[`PSIA_ST_LINK];

  // Remote fault, latched high
  psia_latch #(
    .ACTIVE_LOW (1'b0)
  ) u_rf_latch (
    .pclk    (pclk),
    .presetn (presetn),
    .live    (rf_live_s),
    .clr     (rf_clr),
    .value   (rf_val)
  );

  // Link, latched low
  psia_latch #(
    .ACTIVE_LOW (1'b1)
  ) u_link_latch (
    .pclk    (pclk),
    .presetn (presetn),
    .live    (link_live_s),
    .clr     (link_clr),
    .value   (link_val)
  );

  // Jabber, latched high
  psia_latch #(
    .ACTIVE_LOW (1'b0)
  ) u_jab_latch (
    .pclk    (pclk),
    .presetn (presetn),
    .live    (jab_live_s),
    .clr     (jab_clr),
    .value   (jab_val)
  );

  // Status word as read
  always_comb begin
    status_word                                   = 16'h0000;
    status_word[`PSIA_ST_T4]                      = 1'b0;
    status_word[`PSIA_ST_CAP_HI:`PSIA_ST_CAP_LO]  = `PSIA_ST_CAPS_VAL;
    status_word[`PSIA_ST_PREAMBLE]                = 1'b0;
    status_word[`PSIA_ST_AN_DONE]                 = an_done_s;
    status_word[`PSIA_ST_RFAULT]                  = rf_val;
    status_word[`PSIA_ST_AN_ABLE]                 = 1'b1;
    status_word[`PSIA_ST_LINK]                    = link_val;
    status_word[`PSIA_ST_JABBER]                  = jab_val;
    status_word[`PSIA_ST_EXT]                     = 1'b1;
  end

  // Advertisement word as read
  always_comb begin
    advert_word                                       = 16'h0000;
    advert_word[`PSIA_ADV_NP]                         = 1'b0;
    advert_word[`PSIA_ADV_ACK]                        = ack_s;
    advert_word[`PSIA_ADV_RF]                         = st.adv_rf;
    advert_word[`PSIA_ADV_PAUSE]                      = st.adv_pause;
    advert_word[`PSIA_ADV_T4]                         = 1'b0;
    advert_word[`PSIA_ADV_ABIL_HI:`PSIA_ADV_ABIL_LO]  = st.adv_ability;
    advert_word[`PSIA_ADV_SEL_HI:`PSIA_ADV_SEL_LO]    = st.adv_sel;
  end

  // Next state: capture on setup, write on access
  always_comb begin
    next_st = st;
    if (setup_ph) begin
      next_st.slverr    = (sel_reg == psia_pkg::psia_reg_none);
      next_st.rd_status = ~pwrite & (sel_reg == psia_pkg::psia_reg_status);
      next_st.rdata     = 16'h0000;
      if (!pwrite) begin
        if (sel_reg == psia_pkg::psia_reg_status) begin
          next_st.rdata = status_word;
        end else if (sel_reg == psia_pkg::psia_reg_id_high) begin
          next_st.rdata = ORG_IDENT_UPPER;
        end else if (sel_reg == psia_pkg::psia_reg_id_low) begin
          next_st.rdata = {ORG_IDENT_LOWER, MODEL_NUMBER, REVISION_NUMBER};
        end else if (sel_reg == psia_pkg::psia_reg_advert) begin
          next_st.rdata = advert_word;
        end
      end
    end else if (access_ph) begin
      next_st.rd_status = 1'b0;
    end
    // Writes reach only the writable advertisement fields
    if (wr_adv && pstrb[1]) begin
      next_st.adv_rf         = pwdata[`PSIA_ADV_RF];
      next_st.adv_pause      = pwdata[`PSIA_ADV_PAUSE];
      next_st.adv_ability[3] = pwdata[`PSIA_ADV_ABIL_HI];
    end
    if (wr_adv && pstrb[0]) begin
      next_st.adv_ability[2:0] = pwdata[`PSIA_ADV_ABIL_HI-1:`PSIA_ADV_ABIL_LO];
      next_st.adv_sel          = pwdata[`PSIA_ADV_SEL_HI:`PSIA_ADV_SEL_LO];
    end
  end

  // State register; fixed fields never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{rdata:       16'h0000,
              slverr:      1'b0,
              rd_status:   1'b0,
              adv_rf:      `PSIA_ADV_RF_RST,
              adv_pause:   `PSIA_ADV_PS_RST,
              adv_ability: `PSIA_ADV_ABIL_RST,
              adv_sel:     `PSIA_ADV_SEL_RST};
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign prdata                  = {16'h0000, st.rdata};
  assign pready                  = 1'b1;
  assign pslverr                 = st.slverr;
  assign remote_fault_advert     = st.adv_rf;
  assign pause_advert            = st.adv_pause;
  assign fast_full_duplex_advert = st.adv_ability[3];
  assign fast_half_duplex_advert = st.adv_ability[2];
  assign slow_full_duplex_advert = st.adv_ability[1];
  assign slow_half_duplex_advert = st.adv_ability[0];
  assign advert_selector         = st.adv_sel;

  // Sequences of bus steps
  sequence s_read_of(psia_pkg::psia_reg_t r);
    setup_ph && !pwrite && (sel_reg == r) ##1 access_ph;
  endsequence

  sequence s_adv_write(logic strobe);
    access_ph && pwrite && (sel_reg == psia_pkg::psia_reg_advert) && strobe;
  endsequence

  // Fixed status bits on every status read
  property p_no_t4;
    @(posedge pclk) disable iff (!presetn)
    s_read_of(psia_pkg::psia_reg_status) |-> (prdata[15] == 1'b0);
  endproperty
  a_no_t4: assert property (p_no_t4)
    else $error("status t4 bit not zero");

  property p_caps;
    @(posedge pclk) disable iff (!presetn)
    s_read_of(psia_pkg::psia_reg_status) |-> (prdata[14:11] == 4'hF);
  endproperty
  a_caps: assert property (p_caps)
    else $error("status capability bits not all one");

  property p_reserved;
    @(posedge pclk) disable iff (!presetn)
    s_read_of(psia_pkg::psia_reg_status) |-> (prdata[10:6] == 5'h00);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("status reserved or preamble bits not zero");

  property p_fixed_ones;
    @(posedge pclk) disable iff (!presetn)
    s_read_of(psia_pkg::psia_reg_status) |-> (prdata[3] && prdata[0]);
  endproperty
  a_fixed_ones: assert property (p_fixed_ones)
    else $error("status ability or extended bit not one");

  // Identifier contents and fixed advertisement bits
  property p_id_high;
    @(posedge pclk) disable iff (!presetn)
    s_read_of(psia_pkg::psia_reg_id_high) |-> (prdata == {16'h0000, ORG_IDENT_UPPER});
  endproperty
  a_id_high: assert property (p_id_high)
    else $error("first identifier wrong");

  property p_id_low;
    @(posedge pclk) disable iff (!presetn)
    s_read_of(psia_pkg::psia_reg_id_low)
      |-> (prdata[15:0] == {ORG_IDENT_LOWER, MODEL_NUMBER, REVISION_NUMBER});
  endproperty
  a_id_low: assert property (p_id_low)
    else $error("second identifier wrong");

  property p_adv_fixed;
    @(posedge pclk) disable iff (!presetn)
    s_read_of(psia_pkg::psia_reg_advert) |-> (!prdata[15] && !prdata[9]);
  endproperty
  a_adv_fixed: assert property (p_adv_fixed)
    else $error("advertisement next page or t4 bit set");

  // Writes land in the advertised outputs one edge later
  property p_adv_write;
    @(posedge pclk) disable iff (!presetn)
    s_adv_write(pstrb[1]) |=> (pause_advert == $past(pwdata[10]))
                                 && (remote_fault_advert == $past(pwdata[13]));
  endproperty
  a_adv_write: assert property (p_adv_write)
    else $error("advertisement write not applied");

  property p_sel_write;
    @(posedge pclk) disable iff (!presetn)
    s_adv_write(pstrb[0]) |=> (advert_selector == $past(pwdata[4:0]));
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("selector write not applied");

  // A reported fault clears when the live fault is gone
  property p_rf_clear;
    @(posedge pclk) disable iff (!presetn)
    rd_done && st.rdata[4] && !rf_live_s |=> !rf_val;
  endproperty
  a_rf_clear: assert property (p_rf_clear)
    else $error("remote fault not cleared by read");

  // Latched jabber holds until a read clears it
  property p_jab_hold;
    @(posedge pclk) disable iff (!presetn)
    jab_val && !jab_clr |=> jab_val [*1];
  endproperty
  a_jab_hold: assert property (p_jab_hold)
    else $error("jabber latch dropped without read");

  // A link drop is held low for two cycles at least
  property p_link_low;
    @(posedge pclk) disable iff (!presetn)
    !link_live_s && !link_clr ##1 !link_clr |=> !link_val;
  endproperty
  a_link_low: assert property (p_link_low)
    else $error("link bit followed live level back");

  // Unmapped addresses answer with an error
  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
    setup_ph && (sel_reg == psia_pkg::psia_reg_none) |=> pslverr && (prdata == 32'h00000000);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access without error");

endmodule

`default_nettype wire

// [verilog/psia_sync.sv]
// Two-stage synchroniser for a group of level inputs.
// Assumes inputs may come from any domain; resets to zero.
`timescale 1ns/1ps
`default_nettype none

module psia_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } psia_sync_state_t;

  psia_sync_state_t st;
  psia_sync_state_t next_st;

  // First stage feeds only the second
  always_comb begin
    next_st        = st;
    next_st.meta   = din;
    next_st.stable = st.meta;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.stable;

endmodule

`default_nettype wire

// [verilog/psia_sync_unused_guard.sv]
// Empty file guard not needed.
